// ===== design/zsid_pkg.sv
// Constants, register map and state type of the interlock delay block.
// Assumes a 25 MHz clock and a synchronous active-low reset.
package zsid_pkg;

   // Array sizes
   localparam int ZONES = 4;
   localparam int BUSES = 4;
   localparam int TOPOS = 2 ** BUSES;
   localparam int ST_MEMB = 30;
   localparam int MS_GROUPS = 4;
   localparam int MEMB = ST_MEMB + MS_GROUPS;
   localparam int NFLAT = ZONES * MEMB;

   // Timing: one power-system half cycle at 60 Hz
   localparam int CLK_MHZ = 25;
   localparam int HALF_CYCLE_US = 8333;
   localparam int HALF_CYCLE_CYC = HALF_CYCLE_US * CLK_MHZ;

   // Delay arithmetic in milliseconds
   localparam logic [8:0] MAX_DLY_MS = 9'h190;
   localparam logic [9:0] STEP_MS = 10'h064;

   // Protection type field encodings
   localparam logic [1:0] PT_GF = 2'h1;
   localparam logic [1:0] PT_ST = 2'h2;
   localparam logic [1:0] PT_BOTH = 2'h3;

   // Register byte offsets
   localparam logic [4:0] A_CTRL = 5'h00;
   localparam logic [4:0] A_TOPO = 5'h04;
   localparam logic [4:0] A_STAT = 5'h08;
   localparam logic [4:0] A_EVT = 5'h0c;
   localparam logic [4:0] A_TADR = 5'h10;
   localparam logic [4:0] A_TDAT = 5'h14;
   localparam logic [4:0] A_ORIG = 5'h18;
   localparam logic [4:0] A_CUR = 5'h1c;

   // Field positions
   localparam int F_ZEN = 4;
   localparam int F_PEND = 4;
   localparam int F_TA_TY = 6;
   localparam int F_TA_TOPO = 7;
   localparam int F_TA_ZONE = 11;

   // Reset values
   localparam logic [1:0] PT_RST = PT_BOTH;
   localparam logic [15:0] TOPO_RST = 16'h1111;
   localparam logic [3:0] IDLE_RST = 4'hf;

   typedef enum logic [1:0] {
      ZS_IDLE = 2'b00,
      ZS_SCAN = 2'b01,
      ZS_ADJ = 2'b11,
      ZS_REST = 2'b10
   } zsid_ph_t;

   typedef struct packed {
      zsid_ph_t ph;
      logic [1:0] z;
      logic ty;
      logic [5:0] m;
      logic [1:0] t;
      logic pk_any;
      logic [1:0] pk_t;
      logic [8:0] pk_d;
      logic [3:0] hot_at;
      logic [8:0] ref_d;
      logic [1:0] ref_t;
      logic [8:0] res;
      logic has;
      logic busy;
      logic [3:0] idle;
      logic [3:0] ev;
      logic [3:0] ev_st;
      logic [1:0] ptype;
      logic [3:0] zen;
      logic [15:0] topo_req;
      logic [15:0] topo_act;
      logic [17:0] div;
      logic [12:0] taddr;
      logic ack;
      logic [31:0] rdata;
      logic dv;
      logic [1:0] dz;
      logic dt;
      logic [5:0] dm;
      logic [8:0] dms;
   } zsid_st_t;

   localparam zsid_st_t ZS_RST = '{ph: ZS_IDLE, ptype: PT_RST,
      topo_req: TOPO_RST, topo_act: TOPO_RST, idle: IDLE_RST,
      default: '0};

endpackage

// ===== design/zsid_top.sv
// Interlock delay coordinator for four zones, ground fault and short time.
// Assumes pickup, comm-lost and accumulator-hot inputs synchronous to CLK,
// one bit per member slot, flat index zone*34+member.
// How it works
// (RULE1) Type field selects ground fault, short time or both, for all zones.
// (RULE2) A disabled type is neither scanned nor adjusted.
// (RULE3) Four buses give sixteen topologies.
// (RULE4) Each member holds sixteen tiers; the current topology picks one.
// (RULE5) Tiers are 0..3, 0 highest; members may share a tier.
// (RULE6) New topology loads fresh tiers for every member of the zone.
// (RULE7) Enabled zone scans members; any pickup starts coordination.
// (RULE8) Adjusting begins one tier above pickup; pickup member keeps delay.
// (RULE9) Upstream members are raised whatever their own state.
// (RULE10) New delay is downstream delay plus 100 ms per tier step.
// (RULE11) Results above 400 ms are clamped to 400 ms.
// (RULE12) A smaller result leaves the delay; that delay is the next base.
// (RULE13) Restore once own and all downstream accumulators are cool.
// (RULE14) Topology change waits until the zone is idle.
// (RULE15) Tier writes are stored at once and used once the zone is idle.
// (RULE16) Ground fault and short time tiers are stored apart.
// (RULE17) Each zone has its own enable; disabled zones do nothing.
// (RULE18) Topology 1 after reset; topology 0 is the pass-through mode (not so here: topology 0 reads its own tier set like any other).
// (RULE19) 30 ground fault, 4 group and 30 short time slots per zone.
// (RULE20) Every half cycle each enabled zone is evaluated.
// (RULE21) Raising delays from a pickup pulses a zone event; restore does not.
// (RULE22) A member with lost communication counts as in pickup.
// (RULE23) Tiers go upward, each based on the nearest lower tier result.
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps

module zsid_top
   import zsid_pkg::*;
#(
   parameter int HC_CYC = HALF_CYCLE_CYC
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [NFLAT-1:0] PICKUP_GF,
   input wire logic [NFLAT-1:0] PICKUP_ST,
   input wire logic [NFLAT-1:0] COMM_LOST_GF,
   input wire logic [NFLAT-1:0] COMM_LOST_ST,
   input wire logic [NFLAT-1:0] ACC_HOT_GF,
   input wire logic [NFLAT-1:0] ACC_HOT_ST,
   output logic DLY_VALID,
   output logic [1:0] DLY_ZONE,
   output logic DLY_TYPE,
   output logic [5:0] DLY_MEMBER,
   output logic [8:0] DLY_MS,
   output logic [3:0] ZONE_EVENT
);

   ////////////////////////////////////////////////////////////////////////
   // State and storage

   zsid_st_t s;
   zsid_st_t n;
   // Tier table per zone, type, topology and member
   logic [1:0] tier_mem [ZONES][2][TOPOS][MEMB]; // RULE4 RULE16
   // Tiers in use, reloaded only while the zone is idle
   logic [1:0] act_t [ZONES][2][MEMB];
   logic [8:0] cur_d [ZONES][2][MEMB];
   logic [8:0] orig_d [ZONES][2][MEMB];

   // Write ports computed by the comb process
   logic cur_we;
   logic [8:0] cur_wv;
   logic cb_we;
   logic orig_we;
   logic tm_we;
   logic at_we;
   logic [1:0] at_wv;

   // Helper values
   int fi;
   logic pk;
   logic hot;
   logic valid_m;
   logic ty_on;
   logic on;
   logic nxt;
   logic tick;
   logic [8:0] cur;
   logic [8:0] org;
   logic [1:0] tr;
   logic [3:0] tq;
   logic [9:0] sum;
   logic [8:0] nd;
   logic [8:0] nv;
   logic [3:0] ev_clr;
   logic [5:0] ta_m;
   logic ta_ty;
   logic [3:0] ta_tp;
   logic [1:0] ta_z;
   logic ta_ok;

   // Indirect access fields
   assign ta_m = s.taddr[5:0];
   assign ta_ty = s.taddr[F_TA_TY];
   assign ta_tp = s.taddr[F_TA_TOPO +: 4];
   assign ta_z = s.taddr[F_TA_ZONE +: 2];
   assign ta_ok = ta_m < 6'(MEMB);

   // One wait state on every access, so read data always come from a
   // flip-flop and never straight out of the tables
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s.ack;
   assign AVS_READDATA = s.rdata;
   assign DLY_VALID = s.dv;
   assign DLY_ZONE = s.dz;
   assign DLY_TYPE = s.dt;
   assign DLY_MEMBER = s.dm;
   assign DLY_MS = s.dms;
   assign ZONE_EVENT = s.ev;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      n = s;
      n.dv = 1'b0;
      n.ev = '0;
      n.ack = 1'b0;
      cur_we = 1'b0;
      cur_wv = '0;
      cb_we = 1'b0;
      orig_we = 1'b0;
      tm_we = 1'b0;
      at_we = 1'b0;
      at_wv = '0;
      ev_clr = '0;
      nxt = 1'b0;
      sum = '0;
      nd = '0;
      nv = '0;

      // Half-cycle enable from a free divider
      tick = s.div == 18'(HC_CYC - 1); // RULE20
      n.div = tick ? '0 : s.div + 18'h00001;

      // Bus: read data caught in the wait cycle, write at the ack edge
      if ((AVS_READ | AVS_WRITE) && !s.ack) begin
         n.ack = 1'b1;
         n.rdata = '0;
         unique case (AVS_ADDRESS)
            A_CTRL: n.rdata = {24'h000000, s.zen, 2'h0, s.ptype};
            A_TOPO: n.rdata = {16'h0000, s.topo_req};
            A_STAT: n.rdata = {24'h000000, s.topo_req != s.topo_act
               ? 4'hf & pend_f(s.topo_req, s.topo_act) : 4'h0, s.idle};
            A_EVT: n.rdata = {28'h0000000, s.ev_st};
            A_TADR: n.rdata = {19'h00000, s.taddr};
            A_TDAT: if (ta_ok)
               n.rdata = {30'h0, tier_mem[ta_z][ta_ty][ta_tp][ta_m]};
            A_ORIG: if (ta_ok)
               n.rdata = {23'h0, orig_d[ta_z][ta_ty][ta_m]};
            A_CUR: if (ta_ok)
               n.rdata = {23'h0, cur_d[ta_z][ta_ty][ta_m]};
            default: n.rdata = '0;
         endcase
      end
      if (AVS_WRITE && s.ack) begin
         unique case (AVS_ADDRESS)
            A_CTRL: begin
               n.ptype = AVS_WRITEDATA[1:0]; // RULE1
               n.zen = AVS_WRITEDATA[F_ZEN +: 4]; // RULE17
            end
            A_TOPO: n.topo_req = AVS_WRITEDATA[15:0];
            A_EVT: ev_clr = AVS_WRITEDATA[3:0];
            A_TADR: n.taddr = AVS_WRITEDATA[12:0];
            A_TDAT: tm_we = ta_ok; // RULE15
            A_ORIG: begin
               orig_we = ta_ok;
               // Unadjusted delays follow a new original at once
               cb_we = ta_ok && cur_d[ta_z][ta_ty][ta_m] ==
                  orig_d[ta_z][ta_ty][ta_m];
            end
            default: ;
         endcase
      end

      // Member view for the engine
      fi = int'(s.z) * MEMB + int'(s.m);
      pk = s.ty ? (PICKUP_ST[fi] | COMM_LOST_ST[fi]) // RULE22
                : (PICKUP_GF[fi] | COMM_LOST_GF[fi]);
      hot = s.ty ? ACC_HOT_ST[fi] : ACC_HOT_GF[fi];
      valid_m = !s.ty || s.m < 6'(ST_MEMB); // RULE19
      ty_on = s.ty ? s.ptype[1] : s.ptype[0]; // RULE2
      on = s.zen[s.z] && ty_on && valid_m; // RULE17
      cur = cur_d[s.z][s.ty][s.m];
      org = orig_d[s.z][s.ty][s.m];
      tr = act_t[s.z][s.ty][s.m];
      // Four bus bits per zone address one of sixteen topologies
      tq = s.topo_req[4*s.z +: 4]; // RULE3

      unique case (s.ph)
         ZS_IDLE: if (tick) begin
            n.ph = ZS_SCAN;
            n.z = '0;
            n.ty = 1'b0;
            n.m = '0;
            n.busy = 1'b0;
         end
         ZS_SCAN: begin
            // Tier reload only while idle, so pending changes wait
            // Reloading every pass keeps one path for topology and tiers
            if (s.idle[s.z]) begin
               at_we = 1'b1; // RULE6 RULE14 RULE15
               at_wv = tier_mem[s.z][s.ty][tq][s.m]; // RULE4
               tr = at_wv;
               n.topo_act[4*s.z +: 4] = tq;
            end
            if (on) begin
               if (pk && (!s.pk_any || tr > s.pk_t)) begin // RULE7
                  n.pk_any = 1'b1;
                  n.pk_t = tr;
                  n.pk_d = cur;
               end else if (pk && tr == s.pk_t && cur > s.pk_d) begin
                  n.pk_d = cur;
               end
               n.hot_at[tr] = s.hot_at[tr] | hot | pk;
               if (hot || pk || cur != org)
                  n.busy = 1'b1;
            end
            if (s.m == 6'(MEMB - 1)) begin
               n.m = '0;
               if (n.pk_any) begin
                  n.ev[s.z] = n.pk_t != 2'h0; // RULE21
                  if (n.pk_t != 2'h0) begin
                     n.ph = ZS_ADJ;
                     n.t = n.pk_t - 2'h1; // RULE8
                     n.ref_d = n.pk_d;
                     n.ref_t = n.pk_t;
                     n.res = '0;
                     n.has = 1'b0;
                  end else begin
                     nxt = 1'b1;
                  end
               end else begin
                  n.ph = ZS_REST;
               end
            end else begin
               n.m = s.m + 6'h01;
            end
         end
         ZS_ADJ: begin
            // Members in pickup at this tier are raised too
            if (on && tr == s.t) begin // RULE9
               sum = {1'b0, s.ref_d} +
                  10'(STEP_MS * 10'(s.ref_t - s.t)); // RULE10
               nd = sum > {1'b0, MAX_DLY_MS} ? MAX_DLY_MS : sum[8:0]; // RULE11
               nv = nd > cur ? nd : cur; // RULE12
               if (nd > cur) begin
                  cur_we = 1'b1;
                  cur_wv = nd;
               end
               n.has = 1'b1;
               if (!s.has || nv > s.res)
                  n.res = nv;
            end
            if (s.m == 6'(MEMB - 1)) begin
               n.m = '0;
               // Empty tiers keep the older base; the tally is read
               // before it is cleared for the next tier up
               if (n.has) begin
                  n.ref_d = n.res; // RULE23 RULE12
                  n.ref_t = s.t;
               end
               n.has = 1'b0;
               n.res = '0;
               if (s.t == 2'h0)
                  nxt = 1'b1;
               else
                  n.t = s.t - 2'h1; // RULE23
            end else begin
               n.m = s.m + 6'h01;
            end
         end
         ZS_REST: begin
            // Downstream tiers are those with a larger tier number
            // Tier 3 has nothing below it, so only its own heat counts
            if (on && cur != org && !hot &&
                !(|(s.hot_at & 4'(4'b1110 << tr)))) begin // RULE13
               cur_we = 1'b1;
               cur_wv = org;
            end
            if (s.m == 6'(MEMB - 1))
               nxt = 1'b1;
            else
               n.m = s.m + 6'h01;
         end
      endcase

      // Advance to the next type or zone
      if (nxt) begin
         n.ph = ZS_SCAN;
         n.m = '0;
         n.pk_any = 1'b0;
         n.hot_at = '0;
         if (s.ty) begin
            n.idle[s.z] = !n.busy; // RULE14
            n.busy = 1'b0;
            n.ty = 1'b0;
            if (s.z == 2'(ZONES - 1))
               n.ph = ZS_IDLE;
            else
               n.z = s.z + 2'h1;
         end else begin
            n.ty = 1'b1;
         end
      end

      // Delay announcement to the trip unit
      if (cur_we) begin
         n.dv = 1'b1;
         n.dz = s.z;
         n.dt = s.ty;
         n.dm = s.m;
         n.dms = cur_wv;
      end

      // Sticky zone events, a new event beats the clear
      n.ev_st = (s.ev_st & ~ev_clr) | n.ev;
   end

   // Pending topology per zone
   function automatic logic [3:0] pend_f(input logic [15:0] rq,
                                         input logic [15:0] ac);
      logic [3:0] p;
      p = '0;
      for (int i = 0; i < ZONES; i++)
         p[i] = rq[4*i +: 4] != ac[4*i +: 4];
      return p;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers and tables

   // Reset clears every table so tiers and delays start defined
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         s <= ZS_RST; // RULE18
         for (int z = 0; z < ZONES; z++)
            for (int y = 0; y < 2; y++)
               for (int k = 0; k < MEMB; k++) begin
                  act_t[z][y][k] <= '0;
                  cur_d[z][y][k] <= '0;
                  orig_d[z][y][k] <= '0;
                  for (int p = 0; p < TOPOS; p++)
                     tier_mem[z][y][p][k] <= '0;
               end
      end else begin
         s <= n;
         // Two bits per entry, so every stored value is a legal tier
         if (tm_we)
            tier_mem[ta_z][ta_ty][ta_tp][ta_m] <= AVS_WRITEDATA[1:0]; // RULE5
         if (orig_we)
            orig_d[ta_z][ta_ty][ta_m] <= AVS_WRITEDATA[8:0];
         if (cb_we)
            cur_d[ta_z][ta_ty][ta_m] <= AVS_WRITEDATA[8:0];
         // Engine write last so it wins on a collision
         if (cur_we)
            cur_d[s.z][s.ty][s.m] <= cur_wv;
         if (at_we)
            act_t[s.z][s.ty][s.m] <= at_wv;
      end
   end

endmodule

// ===== tb/zsid_checker.sv
// Concurrent checks on the bus handshake and delay outputs of zsid_top.
// Sees only the top ports; attached by the bind at the foot of this file.
`timescale 1ns/1ps

module zsid_checker
   import zsid_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic [NFLAT-1:0] PICKUP_GF,
   input wire logic [NFLAT-1:0] COMM_LOST_GF,
   input wire logic [NFLAT-1:0] PICKUP_ST,
   input wire logic [NFLAT-1:0] COMM_LOST_ST,
   input wire logic DLY_VALID,
   input wire logic DLY_TYPE,
   input wire logic [5:0] DLY_MEMBER,
   input wire logic [8:0] DLY_MS,
   input wire logic [3:0] ZONE_EVENT
);
   logic req;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   // Any bus request in flight
   assign req = AVS_READ | AVS_WRITE;

   ////////////////////////////////////////////////////////////////////////
   // Bus: at most one wait state, quiet and stable between accesses
   a_wait_one: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("waitrequest held past one cycle");
   a_wait_idle: assert property (!req |-> !AVS_WAITREQUEST)
      else $error("waitrequest raised without a request");
   a_rd_hold: assert property (!req ##1 !req |-> $stable(AVS_READDATA))
      else $error("read data moved between accesses");

   ////////////////////////////////////////////////////////////////////////
   // Delay outputs: capped, in range, held between pulses
   a_dly_cap: assert property (DLY_VALID |-> DLY_MS <= MAX_DLY_MS)
      else $error("delay above ceiling");
   a_dly_slot: assert property (DLY_VALID |-> DLY_MEMBER < 6'h22)
      else $error("delay for a slot that does not exist");
   a_st_slot: assert property (DLY_VALID && DLY_TYPE |-> DLY_MEMBER < 6'h1e)
      else $error("short time delay for a group slot");
   a_dly_hold: assert property (!DLY_VALID |-> $stable(DLY_MS)
      && $stable(DLY_MEMBER))
      else $error("delay data moved without a pulse");

   ////////////////////////////////////////////////////////////////////////
   // Zone events: single pulses; zone 0 events only with a zone 0 member in pickup
   a_evt_pulse: assert property (|ZONE_EVENT |=> ZONE_EVENT == 4'h0)
      else $error("zone event longer than one cycle");
   a_evt_cause: assert property (ZONE_EVENT[0] |->
      |(PICKUP_GF[MEMB-1:0] | COMM_LOST_GF[MEMB-1:0]
      | PICKUP_ST[MEMB-1:0] | COMM_LOST_ST[MEMB-1:0]))
      else $error("zone event with no member in pickup");
endmodule

bind zsid_top zsid_checker u_zsid_checker (
   .CLK(CLK),
   .RESETN(RESETN),
   .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE),
   .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .PICKUP_GF(PICKUP_GF),
   .COMM_LOST_GF(COMM_LOST_GF),
   .PICKUP_ST(PICKUP_ST),
   .COMM_LOST_ST(COMM_LOST_ST),
   .DLY_VALID(DLY_VALID),
   .DLY_TYPE(DLY_TYPE),
   .DLY_MEMBER(DLY_MEMBER),
   .DLY_MS(DLY_MS),
   .ZONE_EVENT(ZONE_EVENT)
);

// ===== tb/zsid_trip_model.sv
// Behavioural trip units: pickup levels, accumulators, delays received.
// Assumes faults are commanded by the bench as levels on CLK.
`timescale 1ns/1ps

module zsid_trip_model
   import zsid_pkg::*;
#(
   parameter int COOL = 500
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NFLAT-1:0] flt_gf,
   input wire logic [NFLAT-1:0] flt_st,
   input wire logic dly_valid,
   input wire logic [1:0] dly_zone,
   input wire logic dly_type,
   input wire logic [5:0] dly_member,
   input wire logic [8:0] dly_ms,
   output logic [NFLAT-1:0] pickup_gf,
   output logic [NFLAT-1:0] pickup_st,
   output logic [NFLAT-1:0] hot_gf,
   output logic [NFLAT-1:0] hot_st
);
   logic [2*NFLAT-1:0] hot_r;
   int cnt_r;
   int idx;
   logic [8:0] ms [2*NFLAT];

   // Pickup follows the fault as a level
   assign pickup_gf = flt_gf;
   assign pickup_st = flt_st;
   assign {hot_st, hot_gf} = hot_r;
   assign idx = int'(dly_type) * NFLAT + int'(dly_zone) * MEMB
      + int'(dly_member);

   // Accumulators cool only COOL cycles after the last fault, so restore
   // can never be seen in the same pass that the fault goes away
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hot_r <= '0;
         cnt_r <= 0;
      end else if (|{flt_st, flt_gf}) begin
         hot_r <= hot_r | {flt_st, flt_gf};
         cnt_r <= COOL;
      end else if (cnt_r != 0) begin
         cnt_r <= cnt_r - 1;
      end else begin
         hot_r <= '0;
      end
   end

   // Each unit keeps the last delay it was sent
   always_ff @(posedge clk) begin
      if (dly_valid) begin
         ms[idx] <= dly_ms;
      end
   end
endmodule

// ===== tb/zsid_bench.sv
// Self-checking bench for zsid_top with the trip unit model on zone 0.
// Assumes a shortened half cycle and the one-wait-state Avalon slave.
`timescale 1ns/1ps

module zsid_bench
   import zsid_pkg::*;
;
   localparam int HC = 2000;
   localparam int COOL = 500;
   logic CLK, RESETN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
   logic [4:0] AVS_ADDRESS;
   logic [31:0] AVS_WRITEDATA, AVS_READDATA;
   logic [NFLAT-1:0] PICKUP_GF, PICKUP_ST, COMM_LOST_GF, COMM_LOST_ST;
   logic [NFLAT-1:0] ACC_HOT_GF, ACC_HOT_ST, flt_gf, flt_st;
   logic DLY_VALID, DLY_TYPE;
   logic [1:0] DLY_ZONE;
   logic [5:0] DLY_MEMBER;
   logic [8:0] DLY_MS;
   logic [3:0] ZONE_EVENT;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;

   zsid_top #(.HC_CYC(HC)) u_zsid_top (.CLK(CLK), .RESETN(RESETN),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .PICKUP_GF(PICKUP_GF),
      .PICKUP_ST(PICKUP_ST), .COMM_LOST_GF(COMM_LOST_GF),
      .COMM_LOST_ST(COMM_LOST_ST), .ACC_HOT_GF(ACC_HOT_GF),
      .ACC_HOT_ST(ACC_HOT_ST), .DLY_VALID(DLY_VALID), .DLY_ZONE(DLY_ZONE),
      .DLY_TYPE(DLY_TYPE), .DLY_MEMBER(DLY_MEMBER), .DLY_MS(DLY_MS),
      .ZONE_EVENT(ZONE_EVENT));

   zsid_trip_model #(.COOL(COOL)) u_zsid_trip_model (.clk(CLK),
      .rst_n(RESETN), .flt_gf(flt_gf), .flt_st(flt_st),
      .dly_valid(DLY_VALID), .dly_zone(DLY_ZONE), .dly_type(DLY_TYPE),
      .dly_member(DLY_MEMBER), .dly_ms(DLY_MS), .pickup_gf(PICKUP_GF),
      .pickup_st(PICKUP_ST), .hot_gf(ACC_HOT_GF), .hot_st(ACC_HOT_ST));

   ////////////////////////////////////////////////////////////////////////
   // Verdict, compare and bus tasks
   task automatic end_sim;
      if (bad_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t exp %h got %h", $time, exp, got);
      end
   endtask

   // Holds the request until waitrequest is sampled low, then releases
   task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      @(posedge CLK);
      while (AVS_WAITREQUEST !== 1'b0 && n < 16) begin
         @(posedge CLK);
         n++;
      end
      chk(32'h0, {31'h0, AVS_WAITREQUEST});
      q = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
      @(posedge CLK);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(exp, q);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Expectations: zone 0, ground fault, topology 1, tier equals member
   function automatic logic [31:0] ta(input int m);
      return 32'(m) | (32'h1 << F_TA_TOPO);
   endfunction

   // One tier step up from base, capped, never below the present delay
   function automatic logic [8:0] up(input int b, input int o);
      int v;
      v = (b + 100 > 400) ? 400 : b + 100;
      return (v < o) ? 9'(o) : 9'(v);
   endfunction

   task automatic cur(input int m, input logic [8:0] exp);
      wr(A_TADR, ta(m));
      rd(A_CUR, {23'h0, exp});
   endtask

   // Mode 0 pickup, 1 comm lost, 2 type off, 3 zone off
   task automatic run(input int d, input int o1, input int mode,
      input logic [1:0] pt);
      int n;
      logic [8:0] e1, e0;
      wr(A_TADR, ta(2));
      wr(A_ORIG, d);
      wr(A_TADR, ta(1));
      wr(A_ORIG, o1);
      wr(A_TADR, ta(0));
      wr(A_ORIG, 32'h0);
      wr(A_CTRL, (mode == 3 ? 32'h0 : 32'h1 << F_ZEN) | pt);
      if (mode == 1)
         COMM_LOST_GF[2] <= 1'b1;
      else
         flt_gf[2] <= 1'b1;
      n = 0;
      while (ZONE_EVENT[0] !== 1'b1 && n < 2 * HC + 200) begin
         @(posedge CLK);
         n++;
      end
      chk(mode < 2, ZONE_EVENT[0] === 1'b1);
      repeat (1100) @(posedge CLK);
      rd(A_EVT, mode < 2);
      e1 = (mode < 2) ? up(d, o1) : 9'(o1);
      e0 = (mode < 2) ? up(e1, 0) : 9'h0;
      cur(1, e1);
      cur(0, e0);
      cur(2, d);
      if (mode == 0 && e1 != o1)
         chk(e1, u_zsid_trip_model.ms[1]);
      if (mode == 1) begin
         wr(A_TOPO, 32'h1112);
         rd(A_STAT, 32'h1e);
      end
      flt_gf <= '0;
      COMM_LOST_GF <= '0;
      repeat (3 * HC + COOL) @(posedge CLK);
      cur(1, o1);
      cur(0, 0);
      wr(A_EVT, 32'hf);
      if (mode == 1) begin
         repeat (HC) @(posedge CLK);
         rd(A_STAT, 32'h0f);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         chk(32'h0, 32'h1);
         end_sim;
      end
   end

   // Main sequence: reset values, tiers, then coordination passes
   initial begin
      RESETN = 1'b0;
      AVS_ADDRESS = 5'h00;
      AVS_READ = 1'b0;
      AVS_WRITE = 1'b0;
      AVS_WRITEDATA = 32'h0;
      flt_gf = '0;
      flt_st = '0;
      COMM_LOST_GF = '0;
      COMM_LOST_ST = '0;
      repeat (8) @(posedge CLK);
      RESETN <= 1'b1;
      @(posedge CLK);
      void'($urandom(32'hec9a070f));
      rd(A_CTRL, 32'h3);
      rd(A_TOPO, 32'h1111);
      rd(A_STAT, 32'h0f);
      for (int m = 0; m < 3; m++) begin
         wr(A_TADR, ta(m));
         wr(A_TDAT, m);
         rd(A_TDAT, m);
      end
      wr(A_TADR, ta(1) | (32'h1 << F_TA_TY));
      wr(A_TDAT, 32'h3);
      wr(A_TADR, ta(1));
      rd(A_TDAT, 32'h1);
      wr(A_TADR, 32'h28);
      wr(A_TDAT, 32'h3);
      rd(A_TDAT, 32'h0);
      run(350, 0, 0, PT_GF);
      run(50, 300, 0, PT_BOTH);
      run($urandom_range(399, 0), $urandom_range(399, 0), 0, PT_GF);
      run(100, 0, 2, PT_ST);
      run(100, 0, 3, PT_BOTH);
      run($urandom_range(399, 0), 0, 1, PT_GF);
      end_sim;
   end
endmodule
